/* translation_pkg.sv */
// translation buffer constants and carrier types
// assumes one processor clock domain
// Functional notes
// - uncached flag has no effect.
// - write hit lacking write-allow raises modification fault.
// - match usable only if valid, else invalid-entry fault.
// - shared entry matches any tag when its page matches.
// - buffer depth set at reset, 4 to 64.
// - user access to kernel segment faults before lookup.
// - addresses below 0x2000_0000 pass untranslated.
// - parallel compare on segment, page, and tag or shared.
// - highest matching slot wins.
// - refill indexes segment table by tag and segment.
// - bad list: low, misaligned, bad marker, end past memory top.
// - refill scan stops at first page and tag match.
// - list end without match: list-miss fault.
// - refill fills random slot 1 to depth-1, never 0.
// - hit: valid, then write-allow, then frame plus offset.
// - slot and victim pointers hold a 6-bit slot field.
// - write-indexed stores holding registers at slot pointer.
// - victim from depth-1 counts down each cycle, wraps after 1.
// - write-random stores at victim slot; victim read-only.
// - read-entry loads pointed slot into holding registers.
// - probe hit loads slot, clears fail flag; miss sets it.
// - flush zeroes entries 1 to depth-1, keeps entry 0.
// - physical address: 20-bit frame in 31:12, 12-bit offset.
// - current space tag is 6 bits in tag holding register.
// - list header: 8-bit marker, 20-bit entry count.
// - list entry: tag-layout word, then data-layout word.
package translation_pkg;

  localparam int          MIN_DEPTH      = 4;
  localparam int          MAX_DEPTH      = 64;
  localparam int          SLOT_W         = 6;
  localparam int          DEPTH_W        = 7;
  localparam logic [31:0] PHYS_TOP       = 32'h2000_0000;
  localparam logic [31:0] SEG_TABLE_BASE = 32'h2000_0500;
  localparam logic [7:0]  LIST_MARKER    = 8'h2a;
  localparam int          SEG_COLUMNS    = 3;
  localparam int          WORD_BYTES     = 4;
  localparam int          PTE_BYTES      = 8;
  localparam int          HDR_BYTES      = 4;
  localparam logic [1:0]  SEG_USER3      = 2'h3;

  // tag holding layout, also list entry word 0
  typedef struct packed {
    logic [1:0]  segment_select;
    logic [17:0] virtual_page_number;
    logic [5:0]  space_tag;
    logic [5:0]  unused;
  } tag_word_t;

  // data holding layout, also list entry word 1
  typedef struct packed {
    logic [19:0] physical_frame_number;
    logic        uncached;
    logic        write_allow;
    logic        valid;
    logic        shared;
    logic [7:0]  unused;
  } data_word_t;

  typedef struct packed {
    logic [7:0]  list_marker;
    logic [3:0]  unused;
    logic [19:0] list_length;
  } list_header_t;

  typedef struct packed {
    logic              probe_fail;
    logic [16:0]       unused_hi;
    logic [SLOT_W-1:0] slot;
    logic [7:0]        unused_lo;
  } pointer_reg_t;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_WRITE_INDEXED,
    OP_WRITE_RANDOM,
    OP_READ_ENTRY,
    OP_PROBE,
    OP_FLUSH
  } cop_op_t;

  typedef enum logic [2:0] {
    FAULT_NONE,
    FAULT_ADDRESS,
    FAULT_INVALID,
    FAULT_MODIFY,
    FAULT_BAD_LIST,
    FAULT_LIST_MISS
  } fault_t;

  typedef struct packed {
    logic [31:0] vaddr;
    logic        is_write;
    logic        user_mode_now;
    logic        vm_on;
  } xlate_req_t;

  typedef struct packed {
    logic [31:0] paddr;
    fault_t      fault;
  } xlate_rsp_t;

endpackage : translation_pkg

/* translation_buffer_unit.sv */
// translation buffer with hardware list walk and coprocessor operations
// assumes one-cycle mem_ack_i pulses and depth_i steady around reset
module translation_buffer_unit #(
  parameter int MAX_DEPTH = translation_pkg::MAX_DEPTH
) (
  input  wire logic                        mclk_i,
  input  wire logic                        resetn_i,
  input  wire logic                        ce_i,
  input  wire logic [6:0]                  depth_i,
  input  wire logic [31:0]                 memory_top_i,
  input  wire logic                        req_valid_i,
  input  wire translation_pkg::xlate_req_t req_i,
  output      logic                        rsp_valid_o,
  output      translation_pkg::xlate_rsp_t rsp_o,
  output      logic                        busy_o,
  input  wire logic                        op_valid_i,
  input  wire translation_pkg::cop_op_t    op_i,
  input  wire logic                        tag_wr_i,
  input  wire logic                        data_wr_i,
  input  wire logic                        slot_wr_i,
  input  wire logic [31:0]                 reg_wdata_i,
  output      translation_pkg::tag_word_t  tag_holding_o,
  output      translation_pkg::data_word_t data_holding_o,
  output      translation_pkg::pointer_reg_t slot_pointer_o,
  output      translation_pkg::pointer_reg_t victim_pointer_o,
  output      logic                        mem_req_o,
  output      logic [31:0]                 mem_addr_o,
  input  wire logic                        mem_ack_i,
  input  wire logic [31:0]                 mem_rdata_i
);

  localparam int SW = translation_pkg::SLOT_W;
  localparam int DW = translation_pkg::DEPTH_W;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHECK,
    ST_SEG_RD,
    ST_HDR_RD,
    ST_PTE_HI,
    ST_PTE_LO,
    ST_FILL
  } state_t;

  state_t                     state;
  translation_pkg::xlate_req_t req_q;
  translation_pkg::tag_word_t  hi_mem [MAX_DEPTH];
  translation_pkg::data_word_t lo_mem [MAX_DEPTH];
  translation_pkg::tag_word_t  pte_hi_q;
  translation_pkg::data_word_t pte_lo_q;
  logic [DW-1:0]              depth_q;
  logic                       cfg_done;
  logic [31:0]                list_base;
  logic [31:0]                pte_addr;
  logic [19:0]                remaining;

  logic [DW-1:0]              next_depth;
  logic [1:0]                 key_seg;
  logic [17:0]                key_vpn;
  logic                       hit;
  logic [SW-1:0]              hit_slot;
  logic                       op_take;
  logic                       idle_free;
  logic [1:0]                 seg_col;
  logic [31:0]                seg_addr;
  logic [32:0]                list_end;
  logic                       kernel_hit;
  logic                       pte_match;
  translation_pkg::tag_word_t  rd_hi;
  translation_pkg::data_word_t rd_lo;
  translation_pkg::list_header_t rd_hdr;
  translation_pkg::pointer_reg_t wr_ptr;

  assign rd_hi     = translation_pkg::tag_word_t'(mem_rdata_i);
  assign rd_lo     = translation_pkg::data_word_t'(mem_rdata_i);
  assign rd_hdr    = translation_pkg::list_header_t'(mem_rdata_i);
  assign wr_ptr    = translation_pkg::pointer_reg_t'(reg_wdata_i);
  assign idle_free = (state == ST_IDLE);
  assign op_take   = idle_free && op_valid_i && (op_i != translation_pkg::OP_NONE);

  // strap clamped into range
  always_comb begin
    next_depth = depth_i;
    if (depth_i < DW'(translation_pkg::MIN_DEPTH)) begin
      next_depth = DW'(translation_pkg::MIN_DEPTH);
    end else if (depth_i > DW'(MAX_DEPTH)) begin
      next_depth = DW'(MAX_DEPTH);
    end
  end

  // depth caught on first enabled edge after release
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      depth_q  <= DW'(translation_pkg::MIN_DEPTH);
      cfg_done <= 1'b0;
    end else if (ce_i && !cfg_done) begin
      depth_q  <= next_depth;
      cfg_done <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      victim_pointer_o <= '0;
    end else if (ce_i) begin
      if (!cfg_done || victim_pointer_o.slot <= SW'(1)) begin
        victim_pointer_o.slot <= SW'(cfg_done ? depth_q - DW'(1) : next_depth - DW'(1));
      end else begin
        victim_pointer_o.slot <= victim_pointer_o.slot - SW'(1);
      end
    end
  end

  // comparators shared by probe and translation
  always_comb begin
    key_seg = tag_holding_o.segment_select;
    key_vpn = tag_holding_o.virtual_page_number;
    if (state == ST_CHECK) begin
      key_seg = req_q.vaddr[31:30];
      key_vpn = req_q.vaddr[29:12];
    end
  end

  always_comb begin
    hit      = 1'b0;
    hit_slot = '0;
    for (int i = 0; i < MAX_DEPTH; i++) begin
      if (DW'(i) < depth_q
          && hi_mem[i].segment_select == key_seg
          && hi_mem[i].virtual_page_number == key_vpn
          && (lo_mem[i].shared || hi_mem[i].space_tag == tag_holding_o.space_tag)) begin
        hit      = 1'b1;
        hit_slot = SW'(i);
      end
    end
  end

  // table column 0 for both kernel codes, 1 and 2 for user
  always_comb begin
    seg_col = (req_q.vaddr[31:30] == translation_pkg::SEG_USER3) ? 2'h2 : {1'b0, req_q.vaddr[31]};
    seg_addr = translation_pkg::SEG_TABLE_BASE
             + (32'(tag_holding_o.space_tag) * 32'(translation_pkg::SEG_COLUMNS) + 32'(seg_col))
             * 32'(translation_pkg::WORD_BYTES);
  end

  assign list_end = {1'b0, list_base} + 33'(translation_pkg::HDR_BYTES)
                  + 33'(rd_hdr.list_length) * 33'(translation_pkg::PTE_BYTES);

  // kernel: codes 00/01 with vm on, low window with vm off
  assign kernel_hit = req_q.vm_on ? ~req_q.vaddr[31] : (req_q.vaddr < translation_pkg::PHYS_TOP);

  assign pte_match = pte_hi_q.segment_select == req_q.vaddr[31:30]
                  && pte_hi_q.virtual_page_number == req_q.vaddr[29:12]
                  && (rd_lo.shared || pte_hi_q.space_tag == tag_holding_o.space_tag);

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state       <= ST_IDLE;
      req_q       <= '0;
      rsp_valid_o <= 1'b0;
      rsp_o       <= '0;
      busy_o      <= 1'b0;
      mem_req_o   <= 1'b0;
      mem_addr_o  <= '0;
      list_base   <= '0;
      pte_addr    <= '0;
      remaining   <= '0;
      pte_hi_q    <= '0;
      pte_lo_q    <= '0;
    end else if (ce_i) begin
      rsp_valid_o <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (req_valid_i && !op_take && cfg_done) begin
            req_q  <= req_i;
            state  <= ST_CHECK;
            busy_o <= 1'b1;
          end
        end
        ST_CHECK: begin
          if (req_q.user_mode_now && kernel_hit) begin
            rsp_o       <= '{paddr: '0, fault: translation_pkg::FAULT_ADDRESS};
            rsp_valid_o <= 1'b1;
            state       <= ST_IDLE;
            busy_o      <= 1'b0;
          end else if (!req_q.vm_on || req_q.vaddr < translation_pkg::PHYS_TOP) begin
            rsp_o       <= '{paddr: req_q.vaddr, fault: translation_pkg::FAULT_NONE};
            rsp_valid_o <= 1'b1;
            state       <= ST_IDLE;
            busy_o      <= 1'b0;
          end else if (hit) begin
            // uncached flag deliberately never consulted
            rsp_valid_o <= 1'b1;
            state       <= ST_IDLE;
            busy_o      <= 1'b0;
            if (!lo_mem[hit_slot].valid) begin
              rsp_o <= '{paddr: '0, fault: translation_pkg::FAULT_INVALID};
            end else if (req_q.is_write && !lo_mem[hit_slot].write_allow) begin
              rsp_o <= '{paddr: '0, fault: translation_pkg::FAULT_MODIFY};
            end else begin
              rsp_o <= '{paddr: {lo_mem[hit_slot].physical_frame_number, req_q.vaddr[11:0]},
                         fault: translation_pkg::FAULT_NONE};
            end
          end else begin
            mem_req_o  <= 1'b1;
            mem_addr_o <= seg_addr;
            state      <= ST_SEG_RD;
          end
        end
        ST_SEG_RD: begin
          if (mem_ack_i) begin
            list_base <= mem_rdata_i;
            if (mem_rdata_i < translation_pkg::PHYS_TOP || mem_rdata_i[1:0] != 2'h0) begin
              mem_req_o   <= 1'b0;
              rsp_o       <= '{paddr: '0, fault: translation_pkg::FAULT_BAD_LIST};
              rsp_valid_o <= 1'b1;
              state       <= ST_IDLE;
              busy_o      <= 1'b0;
            end else begin
              mem_addr_o <= mem_rdata_i;
              state      <= ST_HDR_RD;
            end
          end
        end
        ST_HDR_RD: begin
          if (mem_ack_i) begin
            if (rd_hdr.list_marker != translation_pkg::LIST_MARKER
                || list_end > {1'b0, memory_top_i}) begin
              mem_req_o   <= 1'b0;
              rsp_o       <= '{paddr: '0, fault: translation_pkg::FAULT_BAD_LIST};
              rsp_valid_o <= 1'b1;
              state       <= ST_IDLE;
              busy_o      <= 1'b0;
            end else if (rd_hdr.list_length == 20'h0_0000) begin
              mem_req_o   <= 1'b0;
              rsp_o       <= '{paddr: '0, fault: translation_pkg::FAULT_LIST_MISS};
              rsp_valid_o <= 1'b1;
              state       <= ST_IDLE;
              busy_o      <= 1'b0;
            end else begin
              remaining  <= rd_hdr.list_length;
              pte_addr   <= list_base + 32'(translation_pkg::HDR_BYTES);
              mem_addr_o <= list_base + 32'(translation_pkg::HDR_BYTES);
              state      <= ST_PTE_HI;
            end
          end
        end
        ST_PTE_HI: begin
          if (mem_ack_i) begin
            pte_hi_q   <= rd_hi;
            mem_addr_o <= pte_addr + 32'(translation_pkg::WORD_BYTES);
            state      <= ST_PTE_LO;
          end
        end
        ST_PTE_LO: begin
          if (mem_ack_i) begin
            if (pte_match) begin
              pte_lo_q  <= rd_lo;
              mem_req_o <= 1'b0;
              state     <= ST_FILL;
            end else if (remaining == 20'h0_0001) begin
              mem_req_o   <= 1'b0;
              rsp_o       <= '{paddr: '0, fault: translation_pkg::FAULT_LIST_MISS};
              rsp_valid_o <= 1'b1;
              state       <= ST_IDLE;
              busy_o      <= 1'b0;
            end else begin
              remaining  <= remaining - 20'h0_0001;
              pte_addr   <= pte_addr + 32'(translation_pkg::PTE_BYTES);
              mem_addr_o <= pte_addr + 32'(translation_pkg::PTE_BYTES);
              state      <= ST_PTE_HI;
            end
          end
        end
        ST_FILL: begin
          // retry; the filled slot now answers
          state <= ST_CHECK;
        end
      endcase
    end
  end

  // reset clears every slot so no stale entry matches
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < MAX_DEPTH; i++) begin
        hi_mem[i] <= '0;
        lo_mem[i] <= '0;
      end
    end else if (ce_i) begin
      if (state == ST_FILL) begin
        hi_mem[victim_pointer_o.slot] <= pte_hi_q;
        lo_mem[victim_pointer_o.slot] <= pte_lo_q;
      end else if (op_take) begin
        unique case (op_i)
          translation_pkg::OP_WRITE_INDEXED: begin
            if (DW'(slot_pointer_o.slot) < depth_q) begin
              hi_mem[slot_pointer_o.slot] <= tag_holding_o;
              lo_mem[slot_pointer_o.slot] <= data_holding_o;
            end
          end
          translation_pkg::OP_WRITE_RANDOM: begin
            hi_mem[victim_pointer_o.slot] <= tag_holding_o;
            lo_mem[victim_pointer_o.slot] <= data_holding_o;
          end
          translation_pkg::OP_FLUSH: begin
            for (int i = 1; i < MAX_DEPTH; i++) begin
              if (DW'(i) < depth_q) begin
                hi_mem[i] <= '0;
                lo_mem[i] <= '0;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // writes ignored while a translation is in flight
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tag_holding_o  <= '0;
      data_holding_o <= '0;
    end else if (ce_i) begin
      if (op_take && op_i == translation_pkg::OP_READ_ENTRY) begin
        tag_holding_o  <= hi_mem[slot_pointer_o.slot];
        data_holding_o <= lo_mem[slot_pointer_o.slot];
      end else if (idle_free) begin
        if (tag_wr_i) begin
          tag_holding_o <= translation_pkg::tag_word_t'(reg_wdata_i);
        end
        if (data_wr_i) begin
          data_holding_o <= translation_pkg::data_word_t'(reg_wdata_i);
        end
      end
    end
  end

  // software writes only the slot field
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slot_pointer_o <= '0;
    end else if (ce_i) begin
      if (op_take && op_i == translation_pkg::OP_PROBE) begin
        slot_pointer_o.probe_fail <= ~hit;
        if (hit) begin
          slot_pointer_o.slot <= hit_slot;
        end
      end else if (idle_free && slot_wr_i) begin
        slot_pointer_o.slot <= wr_ptr.slot;
      end
    end
  end

endmodule : translation_buffer_unit

/* translation_buffer_unit_properties.sv */
// port properties of the translation buffer unit
// assumes one clock, depth_i steady around reset
module tbu_properties #(
  parameter int MAX_DEPTH = 64
) (
  input wire logic                          mclk_i,
  input wire logic                          resetn_i,
  input wire logic                          ce_i,
  input wire logic [6:0]                    depth_i,
  input wire logic                          req_valid_i,
  input wire translation_pkg::xlate_req_t   req_i,
  input wire logic                          rsp_valid_o,
  input wire translation_pkg::xlate_rsp_t   rsp_o,
  input wire logic                          busy_o,
  input wire logic                          op_valid_i,
  input wire translation_pkg::cop_op_t      op_i,
  input wire translation_pkg::tag_word_t    tag_holding_o,
  input wire translation_pkg::pointer_reg_t slot_pointer_o,
  input wire translation_pkg::pointer_reg_t victim_pointer_o,
  input wire logic                          mem_req_o,
  input wire logic [31:0]                   mem_addr_o,
  input wire logic                          mem_ack_i,
  input wire logic [31:0]                   mem_rdata_i
);
  localparam logic [31:0] TOP = translation_pkg::PHYS_TOP;
  logic        cfg;
  logic        taken;
  logic [1:0]  seg;
  logic [6:0]  top_slot;
  logic [31:0] tbl_addr;
  assign taken = cfg && ce_i && req_valid_i && !busy_o && !(op_valid_i && op_i != translation_pkg::OP_NONE);
  assign top_slot = depth_i < 7'h4 ? 7'h3 : depth_i > 7'(MAX_DEPTH) ? 7'(MAX_DEPTH - 1) : depth_i - 7'h1;
  // segment codes 0 and 1 share column 0
  assign tbl_addr = translation_pkg::SEG_TABLE_BASE + 32'(tag_holding_o.space_tag) * 12
                    + (seg == 2'h3 ? 32'h8 : seg == 2'h2 ? 32'h4 : 32'h0);
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) {cfg, seg} <= 3'h0;
    else begin
      if (ce_i) cfg <= 1'h1;
      if (taken) seg <= req_i.vaddr[31:30];
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  property p_pass;
    taken && !req_i.user_mode_now && (!req_i.vm_on || req_i.vaddr < TOP) |-> ##2 rsp_valid_o
      && rsp_o.paddr == $past(req_i.vaddr, 2) && rsp_o.fault == translation_pkg::FAULT_NONE;
  endproperty
  a_pass: assert property (p_pass) else $error("no pass-through");
  property p_addr;
    taken && req_i.user_mode_now && (req_i.vm_on ? !req_i.vaddr[31] : req_i.vaddr < TOP)
      |-> ##2 rsp_valid_o && rsp_o.fault == translation_pkg::FAULT_ADDRESS;
  endproperty
  a_addr: assert property (p_addr) else $error("no address fault");
  property p_dec;
    ce_i && victim_pointer_o.slot > 6'h1 |=> victim_pointer_o.slot == $past(victim_pointer_o.slot) - 6'h1;
  endproperty
  a_dec: assert property (p_dec) else $error("victim no decrement");
  property p_wrap;
    ce_i && victim_pointer_o.slot == 6'h1 |=> victim_pointer_o.slot == top_slot[5:0];
  endproperty
  a_wrap: assert property (p_wrap) else $error("victim no reload");
  property p_zero;
    (victim_pointer_o & 32'hffff_c0ff) == 32'h0 && (slot_pointer_o & 32'h7fff_c0ff) == 32'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("spare bits set");
  property p_range;
    cfg |-> victim_pointer_o.slot != 6'h0 && victim_pointer_o.slot <= top_slot[5:0];
  endproperty
  a_range: assert property (p_range) else $error("victim out of range");
  property p_table;
    $rose(mem_req_o) |-> mem_addr_o == tbl_addr;
  endproperty
  a_table: assert property (p_table) else $error("bad table address");
  property p_hold;
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read not held");
  property p_bad;
    mem_ack_i && mem_addr_o >= translation_pkg::SEG_TABLE_BASE && mem_addr_o < 32'h2000_0800
      && (mem_rdata_i < TOP || mem_rdata_i[1:0] != 2'h0)
      |-> ##[1:4] rsp_valid_o && rsp_o.fault == translation_pkg::FAULT_BAD_LIST;
  endproperty
  a_bad: assert property (p_bad) else $error("no bad-list fault");
  property p_fault;
    rsp_valid_o && rsp_o.fault != translation_pkg::FAULT_NONE |-> rsp_o.paddr == 32'h0;
  endproperty
  a_fault: assert property (p_fault) else $error("fault with address");
endmodule : tbu_properties

bind translation_buffer_unit tbu_properties #(.MAX_DEPTH(MAX_DEPTH)) props (.*);

/* list_memory_model.sv */
// word memory serving the list walk
// assumes one read outstanding; the bench fills words before use
module list_memory_model (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        mem_req_i,
  input  wire logic [31:0] mem_addr_i,
  input  wire logic [3:0]  wait_i,
  output      logic        mem_ack_o,
  output      logic [31:0] mem_rdata_o
);
  logic [31:0] words [logic [31:0]];
  logic [3:0]  cnt;
  // data toggles outside the ack so a stale word never matches
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= 4'h0;
      mem_ack_o <= 1'h0;
      mem_rdata_o <= 32'h0;
    end else if (mem_req_i && !mem_ack_o && cnt >= wait_i) begin
      cnt <= 4'h0;
      mem_ack_o <= 1'h1;
      mem_rdata_o <= words.exists(mem_addr_i) ? words[mem_addr_i] : 32'h0;
    end else begin
      cnt <= (mem_req_i && !mem_ack_o) ? cnt + 4'h1 : 4'h0;
      mem_ack_o <= 1'h0;
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule : list_memory_model

/* translation_buffer_unit_test.sv */
// self-checking bench for the translation buffer unit
// assumes the list memory model serves the walk; depth strapped to 8
module translation_buffer_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [31:0] va;
    logic        w, u, v;
    logic [31:0] pa;
    logic [2:0]  f;
  } row_t;
  logic mclk_i = 0, resetn_i = 0, req_valid_i = 0, op_valid_i = 0, tag_wr_i = 0, data_wr_i = 0, slot_wr_i = 0;
  logic mem_req_o, mem_ack_i, rsp_valid_o, busy_o;
  logic [31:0] reg_wdata_i = 0, mem_addr_o, mem_rdata_i;
  logic [3:0] mwait = 4'h3;
  logic [5:0] vs;
  translation_pkg::xlate_req_t req_i = '0;
  translation_pkg::xlate_rsp_t rsp_o, r;
  translation_pkg::cop_op_t op_i = translation_pkg::OP_NONE;
  translation_pkg::tag_word_t tag_holding_o;
  translation_pkg::data_word_t data_holding_o;
  translation_pkg::pointer_reg_t slot_pointer_o, victim_pointer_o;
  int err_count = 0, checks = 0, acks = 0, n;
  row_t rows[9];
  logic [31:0] tw[6];
  always #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (mem_ack_i) acks++;
  translation_buffer_unit DUT (.ce_i(1'h1), .depth_i(7'h8), .memory_top_i(32'h2000_8000), .*);
  list_memory_model mem (.mclk_i, .resetn_i, .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o), .wait_i(mwait),
                         .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
  function automatic logic [31:0] tg(logic [1:0] s, logic [17:0] p, logic [5:0] t);
    return {s, p, t, 6'h0};
  endfunction : tg
  // flag nibble: uncached, write allow, valid, shared
  function automatic logic [31:0] dt(logic [19:0] f, logic [3:0] b);
    return {f, b, 8'h0};
  endfunction : dt
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic xl(input logic [31:0] va, input logic w, u, v);
    int k = 0;
    @(posedge mclk_i);
    req_valid_i <= 1'h1;
    req_i <= '{va, w, u, v};
    @(posedge mclk_i);
    req_valid_i <= 1'h0;
    @(negedge mclk_i);
    chk("busy", busy_o, 1'h1);
    do begin @(negedge mclk_i); k++; end while (rsp_valid_o !== 1'h1 && k < 300);
    if (rsp_valid_o !== 1'h1) begin
      chk("timeout", 32'h0, 32'h1);
      conclude();
    end
    r = rsp_o;
  endtask : xl
  // k: 4 tag, 2 data, 1 slot
  task automatic wreg(input int k, input logic [31:0] d);
    @(posedge mclk_i);
    {tag_wr_i, data_wr_i, slot_wr_i} <= 3'(k);
    reg_wdata_i <= d;
    @(posedge mclk_i);
    {tag_wr_i, data_wr_i, slot_wr_i} <= 3'h0;
    @(negedge mclk_i);
  endtask : wreg
  // codes in enum order; vs is the victim slot as the op is taken
  task automatic op(input int c);
    @(posedge mclk_i);
    op_valid_i <= 1'h1;
    op_i <= translation_pkg::cop_op_t'(c);
    @(negedge mclk_i);
    vs = victim_pointer_o.slot;
    @(posedge mclk_i);
    op_valid_i <= 1'h0;
    op_i <= translation_pkg::OP_NONE;
    @(negedge mclk_i);
  endtask : op
  task automatic put(input logic [5:0] s, input logic [31:0] t, d);
    wreg(4, t);
    wreg(2, d);
    wreg(1, {18'h0, s, 8'h0});
    op(1);
  endtask : put
  initial begin
    // fault codes in enum order
    rows = '{'{32'h1234, 0, 0, 1, 32'h1234, 3'h0}, '{32'h1000_0000, 0, 1, 1, 32'h0, 3'h1},
             '{32'h8001_0abc, 0, 0, 1, 32'h5555_5abc, 3'h0}, '{32'h8001_0abc, 1, 1, 1, 32'h5555_5abc, 3'h0},
             '{32'h8001_1004, 0, 0, 1, 32'h1234_5004, 3'h0}, '{32'h8001_1004, 1, 0, 1, 32'h0, 3'h3},
             '{32'h8001_2000, 1, 0, 1, 32'h0, 3'h2}, '{32'h8001_0abc, 0, 0, 0, 32'h8001_0abc, 3'h0},
             '{32'h2000, 0, 1, 0, 32'h0, 3'h1}};
    tw = '{32'h1000_0000, 32'h2000_1002, 32'h2000_2000, 32'h2000_7000, 32'h2000_4000, 32'h2000_1000};
    mem.words[32'h2000_0544] = 32'h2000_1000;
    mem.words[32'h2000_1000] = 32'h2a00_0002;
    mem.words[32'h2000_1004] = tg(2'h3, 18'h21, 6'h5);
    mem.words[32'h2000_1008] = dt(20'h11111, 4'h6);
    mem.words[32'h2000_100c] = tg(2'h3, 18'h20, 6'h7);
    mem.words[32'h2000_1010] = dt(20'h77777, 4'h7);
    mem.words[32'h2000_2000] = 32'h2b00_0001;
    mem.words[32'h2000_7000] = 32'h2a00_1000;
    mem.words[32'h2000_4000] = 32'h2a00_0000;
    repeat (4) @(posedge mclk_i);
    chk("reset slot pointer", slot_pointer_o, 32'h0);
    chk("reset tag holding", tag_holding_o, 32'h0);
    resetn_i <= 1'h1;
    $display("test reset done");
    put(6'h3, tg(2'h2, 18'h11, 6'h9), dt(20'h12345, 4'h3));
    put(6'h2, tg(2'h2, 18'h10, 6'h5), dt(20'habcde, 4'he));
    put(6'h4, tg(2'h2, 18'h10, 6'h5), dt(20'h55555, 4'h6));
    put(6'h1, tg(2'h2, 18'h12, 6'h5), dt(20'h0abcd, 4'h0));
    foreach (rows[i]) begin
      xl(rows[i].va, rows[i].w, rows[i].u, rows[i].v);
      chk("paddr", r.paddr, rows[i].pa);
      chk("fault", r.fault, rows[i].f);
    end
    $display("test lookup rows done");
    xl(32'hc002_0010, 1'h1, 1'h1, 1'h1);
    chk("refill paddr", r.paddr, 32'h7777_7010);
    n = acks;
    xl(32'hc002_0010, 1'h0, 1'h1, 1'h1);
    chk("refilled hit", r.paddr, 32'h7777_7010);
    chk("no second walk", acks, n);
    wreg(4, tg(2'h3, 18'h20, 6'h5));
    op(4);
    chk("probe hit", slot_pointer_o.probe_fail, 1'h0);
    chk("refill slot", slot_pointer_o.slot == 6'h0, 1'h0);
    $display("test refill done");
    @(posedge mclk_i) mwait <= 4'h0;
    foreach (tw[i]) begin
      mem.words[32'h2000_0540] = tw[i];
      xl(32'h8003_0000, 1'h0, 1'h0, 1'h1);
      chk("list fault", r.fault, i < 4 ? 32'h4 : 32'h5);
    end
    $display("test bad lists done");
    wreg(4, tg(2'h2, 18'h40, 6'h5));
    wreg(2, dt(20'h24680, 4'h6));
    op(2);
    wreg(2, 32'h0);
    wreg(1, {18'h3_ffff, vs, 8'hff});
    chk("slot field only", slot_pointer_o, {18'h0, vs, 8'h0});
    chk("victim not zero", vs == 6'h0, 1'h0);
    op(3);
    chk("random slot data", data_holding_o, dt(20'h24680, 4'h6));
    $display("test write random done");
    put(6'h0, tg(2'h2, 18'h50, 6'h5), dt(20'h13579, 4'h6));
    op(5);
    op(3);
    chk("safe entry", data_holding_o, dt(20'h13579, 4'h6));
    wreg(1, 32'h400);
    op(3);
    chk("flushed tag", tag_holding_o, 32'h0);
    wreg(4, tg(2'h2, 18'h10, 6'h5));
    op(4);
    chk("probe miss", slot_pointer_o, 32'h8000_0400);
    $display("test flush done");
    conclude();
  end
endmodule : translation_buffer_unit_test
